// ---- fepc_cfg.svh ----
`ifndef FEPC_CFG_SVH
`define FEPC_CFG_SVH
// 4B/5B control codes
`define FEPC_SYM_IDLE 5'h1F
`define FEPC_SYM_J 5'h18
`define FEPC_SYM_K 5'h11
`define FEPC_SYM_T 5'h0D
`define FEPC_SYM_R 5'h07
`define FEPC_NIB_JK 4'h5
// Scrambler taps and seed
`define FEPC_LFSR_W 11
`define FEPC_TAP_A 10
`define FEPC_TAP_B 8
`define FEPC_LFSR_SEED 11'h7FF
// Bits per symbol and idle symbols needed for descrambler lock
`define FEPC_SYM_BITS 5
`define FEPC_LOCK_IDLES 4'h4
`endif

// ---- fepc_pkg.sv ----
package fepc_pkg;
   typedef enum logic [2:0] {FEPC_TX_IDLE, FEPC_TX_J, FEPC_TX_K, FEPC_TX_DATA,
      FEPC_TX_T, FEPC_TX_R} fepc_tx_state_t;
   typedef enum logic [2:0] {FEPC_RX_IDLE, FEPC_RX_J, FEPC_RX_DATA,
      FEPC_RX_END, FEPC_RX_BAD} fepc_rx_state_t;
   typedef enum logic [1:0] {FEPC_MLT_NEG, FEPC_MLT_Z1, FEPC_MLT_POS,
      FEPC_MLT_Z2} fepc_mlt_t;
endpackage : fepc_pkg

// ---- fepc_lut.sv ----
`include "fepc_cfg.svh"
module fepc_lut (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Encode side
   input wire logic [3:0] enc_nib,
   output logic [4:0] enc_sym,
   // Decode side
   input wire logic [4:0] dec_sym,
   output logic [3:0] dec_nib,
   output logic dec_data
);
   logic [4:0] enc_rom [0:15];
   logic [4:0] dec_valid_rom [0:31];
   wire [4:0] enc_w;
   wire [4:0] dec_w;
   genvar i;
   // Code table held as constants; decode is the reverse search
   assign enc_rom[0] = 5'h1E;
   assign enc_rom[1] = 5'h09;
   assign enc_rom[2] = 5'h14;
   assign enc_rom[3] = 5'h15;
   assign enc_rom[4] = 5'h0A;
   assign enc_rom[5] = 5'h0B;
   assign enc_rom[6] = 5'h0E;
   assign enc_rom[7] = 5'h0F;
   assign enc_rom[8] = 5'h12;
   assign enc_rom[9] = 5'h13;
   assign enc_rom[10] = 5'h16;
   assign enc_rom[11] = 5'h17;
   assign enc_rom[12] = 5'h1A;
   assign enc_rom[13] = 5'h1B;
   assign enc_rom[14] = 5'h1C;
   assign enc_rom[15] = 5'h1D;
   assign enc_w = enc_rom[enc_nib];
   generate
      for (i = 0; i < 32; i++) begin : g_dec
         logic [4:0] hit;
         always_comb begin
            hit = 5'h00;
            for (int k = 0; k < 16; k++) begin
               if (enc_rom[k] == 5'(i)) begin
                  hit = {1'b1, 4'(k)};
               end
            end
         end
         assign dec_valid_rom[i] = hit;
      end
   endgenerate
   assign dec_w = dec_valid_rom[dec_sym];
   always_ff @(posedge clk) begin
      if (rst) begin
         enc_sym <= `FEPC_SYM_IDLE;
         dec_nib <= 4'h0;
         dec_data <= 1'b0;
      end else begin
         enc_sym <= enc_w; // [R2]
         dec_nib <= dec_w[3:0];
         dec_data <= dec_w[4];
      end
   end
endmodule : fepc_lut

// ---- fepc_codec.sv ----
`include "fepc_cfg.svh"
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Three-bit transmit input is accepted and always forwarded toward the encoder.
// R2: Each nibble maps to its fixed five-bit code from the standard table.
// R3: Idle symbol 11111 is sent between packets.
// R4: First preamble byte becomes J then K; later bytes use the table.
// R5: Received J and K each come out as nibble 0101.
// R6: After the last nibble, T then R are appended.
// R7: Frame fields are not interpreted apart from delimiter substitution.
// R8: Symbols scrambled with 11-bit cipher X[n]=X[n-11] xor X[n-9].
// R9: Scrambled symbols are serialized one bit per line clock.
// R10: MLT-3 holds its level on a zero bit.
// R11: MLT-3 steps negative, zero, positive, zero on each one bit.
// R12: Recovered line bits at 125 MHz feed the MLT-3 decoder.
// R13: After MLT-3 decode the stream is descrambled back to symbols.
// R14: Descrambler locks its 11-bit state while idle is received.
// R15: Decoded nibbles go out to the MAC-side receive unit.
// R16: A code with no meaning at the decoder raises receive error; the code ignores such codes in idle and after a J or end error until idle.
// R17: Loss of link during frame reception raises error.
// R18: Partial start delimiter after idle raises error.
// R19: Idle inside a frame before T R raises error.
// R20: MAC drives transmit bits synchronous to the interface clock.
// R21: Every receive error is flagged to the MAC side for that frame.
// R22: Transmit scrambler starts non-zero after reset.
module fepc_codec
   import fepc_pkg::*;
#(
   parameter int LOCK_IDLES = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // MAC-side transmit
   input wire logic [2:0] mac_tx_bits,
   input wire logic tx_en,
   output logic [3:0] tx_nib,
   output logic tx_nib_valid,
   // Encoder nibble stream, one nibble per symbol slot
   input wire logic sym_stb,
   input wire logic [3:0] enc_nib_in,
   input wire logic enc_frame,
   // Line transmit
   output logic [1:0] mlt_out,
   output logic tx_bit,
   // Line receive
   input wire logic [1:0] mlt_in,
   input wire logic link_ok,
   // MAC-side receive
   output logic [3:0] rx_nib,
   output logic rx_nib_valid,
   output logic rx_dv,
   output logic rx_err,
   output logic rx_locked
);
   import fepc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Transmit input: bits forwarded unconditionally
   logic [2:0] txb_reg;
   logic txv_reg;
   assign tx_nib = {1'b0, txb_reg};
   assign tx_nib_valid = txv_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         txb_reg <= 3'h0;
         txv_reg <= 1'b0;
      end else begin
         txb_reg <= mac_tx_bits; // [R1] [R20]
         txv_reg <= tx_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared code table
   logic [4:0] enc_sym;
   logic [4:0] rx_sym;
   logic [3:0] dec_nib;
   logic dec_data;
   fepc_lut u_lut (
      .clk(clk),
      .rst(rst),
      .enc_nib(enc_nib_in),
      .enc_sym(enc_sym),
      .dec_sym(rx_sym),
      .dec_nib(dec_nib),
      .dec_data(dec_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Transmit framing; the table registers enc_nib_in on every clock and sym_stb is not used
   fepc_tx_state_t tx_state_reg, tx_state_next;
   logic [2:0] bit_cnt_reg;
   logic slot_end;
   logic [4:0] tx_sym;
   logic first_byte_reg;
   assign slot_end = (bit_cnt_reg == 3'(`FEPC_SYM_BITS - 1));
   always_comb begin
      tx_state_next = tx_state_reg;
      case (tx_state_reg)
         // J and T leave in the slot that first sees enc_frame change, so
         // that no offered nibble slot is swallowed by the delimiters
         FEPC_TX_IDLE: if (enc_frame) tx_state_next = FEPC_TX_K; // [R4]
         FEPC_TX_J: tx_state_next = FEPC_TX_K;
         FEPC_TX_K: tx_state_next = FEPC_TX_DATA;
         FEPC_TX_DATA: if (!enc_frame) tx_state_next = FEPC_TX_R; // [R6]
         FEPC_TX_T: tx_state_next = FEPC_TX_R;
         FEPC_TX_R: tx_state_next = FEPC_TX_IDLE;
         default: tx_state_next = FEPC_TX_IDLE;
      endcase
   end
   // Delimiters override the table; fields are otherwise blind [R7]
   always_comb begin
      case (tx_state_reg)
         FEPC_TX_J: tx_sym = `FEPC_SYM_J; // [R4]
         FEPC_TX_K: tx_sym = `FEPC_SYM_K;
         FEPC_TX_DATA: tx_sym = enc_frame ? enc_sym : `FEPC_SYM_T; // [R2] [R6]
         FEPC_TX_T: tx_sym = `FEPC_SYM_T; // [R6]
         FEPC_TX_R: tx_sym = `FEPC_SYM_R;
         FEPC_TX_IDLE: tx_sym = enc_frame ? `FEPC_SYM_J : `FEPC_SYM_IDLE; // [R4]
         default: tx_sym = `FEPC_SYM_IDLE; // [R3]
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Scrambler and serializer, one line bit per clock
   logic [10:0] tx_lfsr_reg;
   logic [4:0] sh_reg;
   logic tx_key;
   logic [1:0] mlt_reg;
   assign tx_key = tx_lfsr_reg[`FEPC_TAP_A] ^ tx_lfsr_reg[`FEPC_TAP_B]; // [R8]
   assign tx_bit = sh_reg[4] ^ tx_key;
   assign mlt_out = mlt_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_state_reg <= FEPC_TX_IDLE;
         bit_cnt_reg <= 3'h0;
         sh_reg <= `FEPC_SYM_IDLE;
         first_byte_reg <= 1'b0;
         tx_lfsr_reg <= `FEPC_LFSR_SEED; // [R22]
         mlt_reg <= FEPC_MLT_Z1;
      end else begin
         tx_lfsr_reg <= {tx_lfsr_reg[9:0], tx_key}; // [R8]
         if (slot_end) begin
            bit_cnt_reg <= 3'h0;
            tx_state_reg <= tx_state_next;
            sh_reg <= tx_sym; // [R9]
            first_byte_reg <= (tx_state_reg == FEPC_TX_J);
         end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            sh_reg <= {sh_reg[3:0], 1'b0}; // [R9]
         end
         if (tx_bit) begin
            mlt_reg <= mlt_reg + 2'h1; // [R11]
         end // [R10] holds on zero
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // MLT-3 decode: a level change is a one
   logic [1:0] mlt_prev_reg;
   logic nrz_bit;
   logic [10:0] rx_lfsr_reg;
   logic rx_key;
   logic plain_bit;
   logic [4:0] rx_sh_reg;
   logic [2:0] rx_cnt_reg;
   logic [3:0] idle_run_reg;
   logic sym_done;
   assign nrz_bit = (mlt_in != mlt_prev_reg); // [R12]
   assign rx_key = rx_lfsr_reg[`FEPC_TAP_A] ^ rx_lfsr_reg[`FEPC_TAP_B];
   // Idle plaintext is all ones, so line bit inverted is the key stream
   assign plain_bit = rx_locked ? (nrz_bit ^ rx_key) : 1'b1; // [R13]
   assign sym_done = (rx_cnt_reg == 3'(`FEPC_SYM_BITS - 1));
   assign rx_sym = {rx_sh_reg[3:0], plain_bit};
   always_ff @(posedge clk) begin
      if (rst) begin
         mlt_prev_reg <= FEPC_MLT_Z1;
         rx_lfsr_reg <= 11'h000;
         rx_sh_reg <= 5'h00;
         rx_cnt_reg <= 3'h0;
         idle_run_reg <= 4'h0;
         rx_locked <= 1'b0;
      end else begin
         mlt_prev_reg <= mlt_in;
         if (rx_locked) begin
            rx_lfsr_reg <= {rx_lfsr_reg[9:0], rx_key};
         end else begin
            rx_lfsr_reg <= {rx_lfsr_reg[9:0], ~nrz_bit}; // [R14]
         end
         rx_sh_reg <= rx_sym;
         rx_cnt_reg <= sym_done ? 3'h0 : rx_cnt_reg + 3'h1;
         if (!link_ok) begin
            rx_locked <= 1'b0;
            idle_run_reg <= 4'h0;
         end else if (!rx_locked && sym_done) begin
            // Lock after LOCK_IDLES+1 symbol ends with link up; received keys are never compared
            if (idle_run_reg >= 4'(LOCK_IDLES)) begin
               rx_locked <= 1'b1; // [R14]
            end
            idle_run_reg <= idle_run_reg + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive framing and error detection
   fepc_rx_state_t rx_state_reg, rx_state_next;
   logic [4:0] sym_q_reg;
   logic sym_v_reg;
   logic err_next;
   logic nib_v_next;
   logic [3:0] nib_next;
   logic sym_idle, sym_j, sym_k, sym_t, sym_r;
   assign sym_idle = (sym_q_reg == `FEPC_SYM_IDLE);
   assign sym_j = (sym_q_reg == `FEPC_SYM_J);
   assign sym_k = (sym_q_reg == `FEPC_SYM_K);
   assign sym_t = (sym_q_reg == `FEPC_SYM_T);
   assign sym_r = (sym_q_reg == `FEPC_SYM_R);
   always_comb begin
      rx_state_next = rx_state_reg;
      err_next = 1'b0;
      nib_v_next = 1'b0;
      nib_next = dec_nib;
      case (rx_state_reg)
         FEPC_RX_IDLE: if (sym_j) begin
            rx_state_next = FEPC_RX_J;
            nib_v_next = 1'b1;
            nib_next = `FEPC_NIB_JK; // [R5]
         end else if (sym_k) begin
            err_next = 1'b1; // [R18]
         end
         FEPC_RX_J: if (sym_k) begin
            rx_state_next = FEPC_RX_DATA;
            nib_v_next = 1'b1;
            nib_next = `FEPC_NIB_JK; // [R5]
         end else begin
            rx_state_next = sym_idle ? FEPC_RX_IDLE : FEPC_RX_BAD;
            err_next = 1'b1; // [R18]
         end
         FEPC_RX_DATA: if (sym_t) begin
            rx_state_next = FEPC_RX_END;
         end else if (sym_idle) begin
            rx_state_next = FEPC_RX_IDLE;
            err_next = 1'b1; // [R19]
         end else if (dec_data) begin
            nib_v_next = 1'b1; // [R15]
         end else begin
            err_next = 1'b1; // [R16]
         end
         FEPC_RX_END: begin
            rx_state_next = sym_r ? FEPC_RX_IDLE : FEPC_RX_BAD;
            err_next = !sym_r; // [R16]
         end
         FEPC_RX_BAD: if (sym_idle) rx_state_next = FEPC_RX_IDLE;
         default: rx_state_next = FEPC_RX_IDLE;
      endcase
      if (!link_ok && rx_state_reg != FEPC_RX_IDLE) begin
         rx_state_next = FEPC_RX_IDLE;
         nib_v_next = 1'b0;
         err_next = 1'b1; // [R17]
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         sym_q_reg <= `FEPC_SYM_IDLE;
         sym_v_reg <= 1'b0;
         rx_state_reg <= FEPC_RX_IDLE;
         rx_nib <= 4'h0;
         rx_nib_valid <= 1'b0;
         rx_dv <= 1'b0;
         rx_err <= 1'b0;
      end else begin
         sym_v_reg <= sym_done && rx_locked;
         if (sym_done) begin
            sym_q_reg <= rx_sym;
         end
         rx_nib_valid <= 1'b0;
         rx_err <= 1'b0;
         if (sym_v_reg || (!link_ok && rx_state_reg != FEPC_RX_IDLE)) begin
            rx_state_reg <= rx_state_next;
            rx_nib <= nib_next; // [R15]
            rx_nib_valid <= nib_v_next;
            rx_err <= err_next; // [R21]
            rx_dv <= (rx_state_next != FEPC_RX_IDLE);
         end
      end
   end
endmodule : fepc_codec

// ---- fepc_far_tx.sv ----
module fepc_far_tx (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Symbol for the next slot, taken at slot end
   input wire logic [4:0] sym,
   output logic slot_end,
   // Line side
   output logic [1:0] mlt
);
   logic [2:0] cnt_reg;
   logic [4:0] sym_reg;
   logic [10:0] lfsr_reg;
   logic key;
   logic bit_nrz;
   logic [1:0] mlt_reg;
   ////////////////////////////////////////////////////////////////////////////
   // Seed differs from the design's so the receiver must really lock
   assign slot_end = (cnt_reg == 3'h4);
   assign key = lfsr_reg[10] ^ lfsr_reg[8];
   assign bit_nrz = sym_reg[3'h4 - cnt_reg] ^ key;
   // Level shows the current bit at once, so the receiver's window lines up
   assign mlt = bit_nrz ? mlt_reg + 2'h1 : mlt_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 3'h0;
         sym_reg <= 5'h1F;
         lfsr_reg <= 11'h2A5;
         mlt_reg <= 2'h1;
      end else begin
         cnt_reg <= slot_end ? 3'h0 : cnt_reg + 3'h1;
         if (slot_end) begin
            sym_reg <= sym;
         end
         lfsr_reg <= {lfsr_reg[9:0], key};
         if (bit_nrz) begin
            mlt_reg <= mlt_reg + 2'h1;
         end
      end
   end
endmodule : fepc_far_tx

// ---- fepc_chk.sv ----
module fepc_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Transmit side
   input wire logic [2:0] mac_tx_bits,
   input wire logic tx_en,
   input wire logic [3:0] tx_nib,
   input wire logic tx_nib_valid,
   input wire logic enc_frame,
   input wire logic [1:0] mlt_out,
   input wire logic tx_bit,
   // Receive side
   input wire logic link_ok,
   input wire logic rx_nib_valid,
   input wire logic rx_dv,
   input wire logic rx_err,
   input wire logic rx_locked
);
   logic [5:0] idle_cnt_reg;
   logic [3:0] ones_cnt_reg;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // Idle age, then run of ones once the line is surely idle
   always_ff @(posedge clk) begin
      if (rst || enc_frame) begin
         idle_cnt_reg <= 6'h00;
      end else if (idle_cnt_reg != 6'h3F) begin
         idle_cnt_reg <= idle_cnt_reg + 6'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || !tx_bit || idle_cnt_reg < 6'h30) begin
         ones_cnt_reg <= 4'h0;
      end else if (ones_cnt_reg != 4'hF) begin
         ones_cnt_reg <= ones_cnt_reg + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   tx_pass_a:
      assert property (!rst |=> tx_nib == {1'b0, $past(mac_tx_bits)}
         && tx_nib_valid == $past(tx_en)) else $error("tx bits not passed");
   mlt_hold_a:
      assert property (!tx_bit |=> $stable(mlt_out))
      else $error("mlt level moved on zero");
   mlt_step_a:
      assert property (tx_bit |=> mlt_out == $past(mlt_out) + 2'h1)
      else $error("mlt level did not step");
   idle_code_a:
      assert property (idle_cnt_reg >= 6'h30 |->
         tx_bit == !($past(tx_bit, 11) ^ $past(tx_bit, 9)))
      else $error("idle stream off cipher");
   seed_live_a:
      assert property (ones_cnt_reg <= 4'hA) else $error("cipher stuck");
   link_err_a:
      assert property ($fell(link_ok) && rx_dv |-> ##[0:12] rx_err)
      else $error("link loss not flagged");
   nib_gap_a:
      assert property (rx_nib_valid |=> !rx_nib_valid [*4])
      else $error("nibbles closer than a symbol");
   lock_gate_a:
      assert property (!rx_locked |-> !rx_nib_valid && !rx_dv)
      else $error("receive output while unlocked");
endmodule : fepc_chk

bind fepc_codec fepc_chk u_chk (.clk(clk), .rst(rst),
   .mac_tx_bits(mac_tx_bits), .tx_en(tx_en), .tx_nib(tx_nib),
   .tx_nib_valid(tx_nib_valid), .enc_frame(enc_frame), .mlt_out(mlt_out),
   .tx_bit(tx_bit), .link_ok(link_ok), .rx_nib_valid(rx_nib_valid),
   .rx_dv(rx_dv), .rx_err(rx_err), .rx_locked(rx_locked));

// ---- fast_ethernet_pcs_codec_tb_top.sv ----
module fast_ethernet_pcs_codec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
      5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
      5'h1D};
   // Rows: {tx_en, mac_tx_bits} beside {tx_nib_valid, tx_nib}
   localparam logic [8:0] ROWS [8] = '{9'h000, 9'h1F7, 9'h042, 9'h1B5,
      9'h084, 9'h173, 9'h0C6, 9'h131};
   // Bad receive runs; the last loses link in its fourth slot
   localparam logic [4:0] BAD [6][6] = '{
      '{5'h18, 5'h11, 5'h00, 5'h0D, 5'h07, 5'h1F},
      '{5'h18, 5'h11, 5'h04, 5'h0D, 5'h07, 5'h1F},
      '{5'h18, 5'h09, 5'h09, 5'h1F, 5'h1F, 5'h1F},
      '{5'h11, 5'h09, 5'h09, 5'h1F, 5'h1F, 5'h1F},
      '{5'h18, 5'h11, 5'h09, 5'h1F, 5'h1F, 5'h1F},
      '{5'h18, 5'h11, 5'h09, 5'h09, 5'h0D, 5'h07}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] mac_tx_bits = 3'h0;
   logic tx_en = 1'b0;
   logic [3:0] enc_nib_in = 4'h0;
   logic enc_frame = 1'b0;
   logic link_ok = 1'b1;
   logic [4:0] far_sym = 5'h1F;
   logic [1:0] mlt_in, mlt_out;
   logic [3:0] tx_nib, rx_nib;
   logic tx_nib_valid, tx_bit, rx_nib_valid, rx_dv, rx_err, rx_locked;
   logic slot_end, kp;
   logic [10:0] kh = 11'h000;
   logic [4:0] sh = 5'h00;
   logic [1:0] phase = 2'h0;
   int errors = 0;
   int num_checks = 0;
   int rx_errs = 0;
   int bc = 0;
   int base;
   logic [4:0] txq [$];
   logic [3:0] rxq [$];
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 clk = ~clk;
   end
   fepc_codec uut (.clk(clk), .rst(rst), .mac_tx_bits(mac_tx_bits),
      .tx_en(tx_en), .tx_nib(tx_nib), .tx_nib_valid(tx_nib_valid),
      .sym_stb(1'b0), .enc_nib_in(enc_nib_in), .enc_frame(enc_frame),
      .mlt_out(mlt_out), .tx_bit(tx_bit), .mlt_in(mlt_in),
      .link_ok(link_ok), .rx_nib(rx_nib), .rx_nib_valid(rx_nib_valid),
      .rx_dv(rx_dv), .rx_err(rx_err), .rx_locked(rx_locked));
   fepc_far_tx far (.clk(clk), .rst(rst), .sym(far_sym),
      .slot_end(slot_end), .mlt(mlt_in));
   ////////////////////////////////////////////////////////////////////////////
   // Key learnt from idle, then run on by the same recurrence
   assign kp = kh[10] ^ kh[8];
   always @(posedge clk) begin
      kh <= {kh[9:0], phase == 2'h1 ? ~tx_bit : kp};
      sh <= {sh[3:0], tx_bit ^ kp};
      if (bc > 0 && txq.size() < 20) begin
         bc = (bc == 5) ? 1 : bc + 1;
         if (bc == 1) txq.push_back({sh[3:0], tx_bit ^ kp});
      end else if (phase == 2'h2 && txq.size() == 0
         && {sh[3:0], tx_bit ^ kp} == 5'h18) begin
         txq.push_back(5'h18);
         bc = 1;
      end
      if (rx_nib_valid === 1'b1) rxq.push_back(rx_nib);
      if (rx_err === 1'b1) rx_errs++;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // Both sides load at the same slot end edge
   task automatic put(input logic [3:0] n, input logic [4:0] s,
      input logic f);
      repeat (5) begin
         @(negedge clk);
         if (slot_end === 1'b1) break;
      end
      @(posedge clk);
      enc_nib_in <= n;
      far_sym <= s;
      enc_frame <= f;
   endtask : put
   task automatic idles(input int k);
      repeat (k) put(4'h0, 5'h1F, 1'b0);
   endtask : idles
   task automatic test_done;
      if (errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (ROWS[i]) begin
         @(posedge clk);
         {tx_en, mac_tx_bits} <= ROWS[i][8:5];
         @(posedge clk);
         #1 chk({tx_nib_valid, tx_nib}, ROWS[i][4:0]);
      end
      idles(4);
      phase <= 2'h1;
      idles(6);
      phase <= 2'h2;
      put(4'h5, 5'h1F, 1'b1);
      put(4'h5, 5'h1F, 1'b1);
      for (int i = 0; i < 16; i++) put(i[3:0], 5'h1F, 1'b1);
      idles(8);
      chk(txq[0], 5'h18);
      chk(txq[1], 5'h11);
      for (int i = 0; i < 16; i++) chk(txq[i + 2], CODE[i]);
      chk(txq[18], 5'h0D);
      chk(txq[19], 5'h07);
      @(negedge clk);
      rxq.delete();
      base = rx_errs;
      chk(rx_locked, 1'b1);
      put(4'h0, 5'h18, 1'b0);
      put(4'h0, 5'h11, 1'b0);
      for (int i = 0; i < 16; i++) put(4'h0, CODE[i], 1'b0);
      put(4'h0, 5'h0D, 1'b0);
      put(4'h0, 5'h07, 1'b0);
      idles(3);
      @(negedge clk);
      chk(rxq[0], 4'h5);
      chk(rxq[1], 4'h5);
      for (int i = 0; i < 16; i++) chk(rxq[i + 2], i[3:0]);
      chk(rxq.size(), 18);
      chk(rx_errs - base, 0);
      chk(rx_dv, 1'b0);
      foreach (BAD[c]) begin
         @(negedge clk);
         base = rx_errs;
         foreach (BAD[c][j]) begin
            put(4'h0, BAD[c][j], 1'b0);
            link_ok <= !(c == 5 && j == 3);
         end
         idles(14);
         @(negedge clk);
         chk(rx_errs != base, 1'b1);
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      #1 chk({mlt_out, rx_locked, rx_dv, rx_err, rx_nib_valid}, 6'h10);
      @(posedge clk);
      rst <= 1'b0;
      idles(20);
      test_done();
   end
endmodule : fast_ethernet_pcs_codec_tb_top
